// ===== design/questionable_summary_bit_consts.svh
// constants for the questionable status group: offsets, bit positions, resets
// assumes a 32-bit apb slave with word-aligned registers
`ifndef QUESTIONABLE_SUMMARY_BIT_CONSTS_SVH
`define QUESTIONABLE_SUMMARY_BIT_CONSTS_SVH
// ==========================================
// register byte offsets
`define QS_OFF_COND 12'h000
`define QS_OFF_RISE 12'h004
`define QS_OFF_FALL 12'h008
`define QS_OFF_EVT 12'h00C
`define QS_OFF_MASK 12'h010
`define QS_OFF_IRQ_STAT 12'h014
`define QS_OFF_IRQ_MASK 12'h018
// ==========================================
// condition bit positions
`define QS_BIT_OTP 4
`define QS_BIT_VL 8
`define QS_BIT_CL 9
`define QS_BIT_SD 11
`define QS_BIT_PL 12
`define QS_BIT_SA 13
`define QS_BIT_IS 14
`define QS_USED_MASK 16'h7B10
// ==========================================
// reset values
`define QS_RST_RISE 16'h7B10
`define QS_RST_FALL 16'h0000
`define QS_RST_MASK 16'h0000
`define QS_RST_IRQ_MASK 2'b00
`endif

// ===== design/questionable_summary_bit_pkg.sv
// types for the questionable status group
// assumes the constants header is included by the design files
package questionable_summary_bit_pkg;
    typedef logic [15:0] word16_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_t;
    typedef struct packed {
        logic [15:0] cond_a;
        logic [15:0] cond_b;
        logic [15:0] chain_a;
        logic [15:0] chain_b;
    } sync_state_t;
    typedef struct packed {
        bus_state_t bus;
        word16_t cond;
        word16_t rise;
        word16_t fall;
        word16_t evt;
        word16_t mask;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic summary;
        logic irq;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
    } core_state_t;
endpackage

// ===== design/questionable_summary_bit_sync.sv
// two-flop synchroniser for the live condition pins
// assumes pins are asynchronous to the core clock
`timescale 1ns/1ps
`include "questionable_summary_bit_consts.svh"
module questionable_summary_bit_sync #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // raw and synced condition words
    input wire logic [WIDTH-1:0] i_raw,
    input wire logic [WIDTH-1:0] i_chain,
    output logic [WIDTH-1:0] o_cond,
    output logic [WIDTH-1:0] o_chain
);
    questionable_summary_bit_pkg::sync_state_t s_q;
    questionable_summary_bit_pkg::sync_state_t s_d;
    always_comb begin
        s_d = s_q;
        s_d.cond_a = i_raw;
        s_d.cond_b = s_q.cond_a;
        s_d.chain_a = i_chain;
        s_d.chain_b = s_q.chain_a;
    end
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign o_cond = s_q.cond_b;
    assign o_chain = s_q.chain_b;
endmodule // questionable_summary_bit_sync

// ===== design/questionable_status_group.sv
// questionable status group: condition, transition filters, event latch, summary
// assumes an apb master on the core clock; condition pins are asynchronous
// What this block does
// - over-temperature trip drives condition bit 4
// - voltage limit bit 8, current limit bit 9
// - shutdown 11, power limit 12, sense 13
// - bit 14 summarises chained units' trips
// - condition mirrors inputs; read changes nothing
// - per-bit rising and falling filter registers
// - enabled rising edge sets event bit
// - enabled falling edge sets event bit
// - summary high when masked event set
// - event read returns latch then clears
`timescale 1ns/1ps
`include "questionable_summary_bit_consts.svh"
module questionable_status_group (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic O_PREADY,
    output logic O_PSLVERR,
    output logic [31:0] O_PRDATA,
    // monitored conditions
    input wire logic I_OVER_TEMP_TRIP,
    input wire logic I_VOLTAGE_LIMIT_REACHED,
    input wire logic I_CURRENT_LIMIT_REACHED,
    input wire logic I_SHUTDOWN_ALARM,
    input wire logic I_POWER_LIMIT_REACHED,
    input wire logic I_SENSE_ALARM,
    input wire logic [15:0] I_CHAINED_UNIT_STATUS,
    // status outputs
    output logic O_QUESTIONABLE_SUMMARY_BIT,
    output logic O_IRQ
);

    // ==========================================
    // condition assembly and synchronisation
    logic [15:0] raw_cond;
    logic [15:0] sync_cond;
    logic [15:0] sync_chain;
    logic [15:0] live_cond;
    always_comb begin
        raw_cond = 16'h0000;
        raw_cond[`QS_BIT_OTP] = I_OVER_TEMP_TRIP;
        raw_cond[`QS_BIT_VL] = I_VOLTAGE_LIMIT_REACHED;
        raw_cond[`QS_BIT_CL] = I_CURRENT_LIMIT_REACHED;
        raw_cond[`QS_BIT_SD] = I_SHUTDOWN_ALARM;
        raw_cond[`QS_BIT_PL] = I_POWER_LIMIT_REACHED;
        raw_cond[`QS_BIT_SA] = I_SENSE_ALARM;
    end
    questionable_summary_bit_sync #(
        .WIDTH(16)
    ) u_sync (
        .i_clk(I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_raw(raw_cond),
        .i_chain(I_CHAINED_UNIT_STATUS),
        .o_cond(sync_cond),
        .o_chain(sync_chain)
    );
    always_comb begin
        live_cond = sync_cond;
        // any chained unit reporting any used trip raises condition bit 14
        live_cond[`QS_BIT_IS] = |(sync_chain & `QS_USED_MASK);
        live_cond = live_cond & `QS_USED_MASK;
    end

    // ==========================================
    // state
    // one struct holds every register, so reset and update stay together
    questionable_summary_bit_pkg::core_state_t s_q;
    questionable_summary_bit_pkg::core_state_t s_d;
    // assigned positions only; every other bit is forced to zero
    localparam logic [15:0] used_bits = `QS_USED_MASK;

    // ==========================================
    // bus phase decode
    // the answer comes in the first access cycle: no wait states
    // an access only counts once its setup has moved the bus state on
    logic setup;
    logic access;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    always_comb begin
        setup = I_PSEL && !I_PENABLE;
        access = (s_q.bus == questionable_summary_bit_pkg::BUS_ACCESS) && I_PSEL && I_PENABLE;
        wr = access && I_PWRITE;
        rd = access && !I_PWRITE;
        wdata = I_PWDATA[15:0];
    end

    // ==========================================
    // register selects
    // an offset that matches no select gets an error and changes nothing
    logic sel_cond;
    logic sel_rise;
    logic sel_fall;
    logic sel_evt;
    logic sel_mask;
    logic sel_irq_stat;
    logic sel_irq_mask;
    logic sel_none;
    always_comb begin
        sel_cond = (I_PADDR == `QS_OFF_COND);
        sel_rise = (I_PADDR == `QS_OFF_RISE);
        sel_fall = (I_PADDR == `QS_OFF_FALL);
        sel_evt = (I_PADDR == `QS_OFF_EVT);
        sel_mask = (I_PADDR == `QS_OFF_MASK);
        sel_irq_stat = (I_PADDR == `QS_OFF_IRQ_STAT);
        sel_irq_mask = (I_PADDR == `QS_OFF_IRQ_MASK);
        sel_none = !(sel_cond || sel_rise || sel_fall || sel_evt || sel_mask
            || sel_irq_stat || sel_irq_mask);
    end

    // ==========================================
    // write enables
    // 16-bit registers need both low strobes; irq registers only one
    // cond and event have no enable: writes to them are ignored
    logic we_rise;
    logic we_fall;
    logic we_mask;
    logic we_irq_stat;
    logic we_irq_mask;
    always_comb begin
        we_rise = wr && sel_rise && I_PSTRB[0] && I_PSTRB[1];
        we_fall = wr && sel_fall && I_PSTRB[0] && I_PSTRB[1];
        we_mask = wr && sel_mask && I_PSTRB[0] && I_PSTRB[1];
        we_irq_stat = wr && sel_irq_stat && I_PSTRB[0];
        we_irq_mask = wr && sel_irq_mask && I_PSTRB[0];
    end

    // ==========================================
    // per-bit transition filters and event latch
    // cond holds last cycle's word, so each change of a live bit shows
    // on exactly one edge; that edge is its only chance to latch
    wire logic [15:0] rise_hit;
    wire logic [15:0] fall_hit;
    wire logic [15:0] evt_set;
    wire logic [15:0] evt_next;
    logic evt_clear;
    assign evt_clear = rd && sel_evt;
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_bit
            // the two filters pick which direction of change counts
            assign rise_hit[gi] = !s_q.cond[gi] && live_cond[gi] && s_q.rise[gi];
            assign fall_hit[gi] = s_q.cond[gi] && !live_cond[gi] && s_q.fall[gi];
            // unassigned positions can never latch, whatever the filters hold
            assign evt_set[gi] = (rise_hit[gi] || fall_hit[gi]) && used_bits[gi];
            // a read clears the latch, but an edge in the same cycle survives
            assign evt_next[gi] = evt_set[gi] || (s_q.evt[gi] && !evt_clear);
        end
    endgenerate

    // ==========================================
    // read data
    // taken from the registers in setup, so it stands unchanged at the
    // ready edge even when an event clear lands on that same edge
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        case (1'b1)
            sel_cond: begin
                rd_word[15:0] = s_q.cond;
            end
            sel_rise: begin
                rd_word[15:0] = s_q.rise;
            end
            sel_fall: begin
                rd_word[15:0] = s_q.fall;
            end
            sel_evt: begin
                rd_word[15:0] = s_q.evt;
            end
            sel_mask: begin
                rd_word[15:0] = s_q.mask;
            end
            sel_irq_stat: begin
                rd_word[1:0] = s_q.irq_stat;
            end
            sel_irq_mask: begin
                rd_word[1:0] = s_q.irq_mask;
            end
            default: begin
            end
        endcase
    end

    // ==========================================
    // summary and interrupt sources
    // the summary uses the values being loaded, so it changes on the same
    // edge as its event bit; irq bit0 is a new event, bit1 a rising summary
    logic [15:0] mask_next;
    logic summary_next;
    logic [1:0] irq_set;
    always_comb begin
        mask_next = s_q.mask;
        if (we_mask) begin
            mask_next = wdata & used_bits;
        end
        summary_next = |(evt_next & mask_next);
        irq_set = {summary_next & ~s_q.summary, |evt_set};
    end

    // ==========================================
    // interrupt status and mask
    // a new source in the same cycle as a write-one-to-clear wins
    // the mask has no sticky part: a write simply replaces it
    logic [1:0] irq_stat_next;
    logic [1:0] irq_mask_next;
    always_comb begin
        irq_stat_next = s_q.irq_stat | irq_set;
        if (we_irq_stat) begin
            irq_stat_next = (s_q.irq_stat & ~I_PWDATA[1:0]) | irq_set;
        end
        irq_mask_next = s_q.irq_mask;
        if (we_irq_mask) begin
            irq_mask_next = I_PWDATA[1:0];
        end
    end

    // ==========================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.ready = 1'b0;
        s_d.slverr = 1'b0;
        // ready and the error flag pulse for the one access cycle
        case (s_q.bus)
            questionable_summary_bit_pkg::BUS_IDLE: begin
                if (setup) begin
                    s_d.bus = questionable_summary_bit_pkg::BUS_ACCESS;
                    s_d.ready = 1'b1;
                    s_d.slverr = sel_none;
                    s_d.rdata = rd_word;
                end
            end
            questionable_summary_bit_pkg::BUS_ACCESS: begin
                s_d.bus = questionable_summary_bit_pkg::BUS_IDLE;
            end
            default: begin
                s_d.bus = questionable_summary_bit_pkg::BUS_IDLE;
            end
        endcase
        // condition word tracks the live inputs every cycle
        s_d.cond = live_cond;
        if (we_rise) begin
            s_d.rise = wdata & used_bits;
        end
        if (we_fall) begin
            s_d.fall = wdata & used_bits;
        end
        s_d.mask = mask_next;
        s_d.evt = evt_next;
        s_d.summary = summary_next;
        s_d.irq_stat = irq_stat_next;
        s_d.irq_mask = irq_mask_next;
        s_d.irq = |(irq_stat_next & irq_mask_next);
    end

    // ==========================================
    // registers
    // synchronous reset; every output below comes straight from here
    // cond resets low, so a pin already high at release counts as a rise
    always_ff @(posedge I_CORE_CLK) begin
        if (!I_RESET_N) begin
            s_q.bus <= questionable_summary_bit_pkg::BUS_IDLE;
            s_q.cond <= 16'h0000;
            s_q.rise <= `QS_RST_RISE;
            s_q.fall <= `QS_RST_FALL;
            s_q.evt <= 16'h0000;
            s_q.mask <= `QS_RST_MASK;
            s_q.irq_stat <= 2'b00;
            s_q.irq_mask <= `QS_RST_IRQ_MASK;
            s_q.summary <= 1'b0;
            s_q.irq <= 1'b0;
            s_q.ready <= 1'b0;
            s_q.slverr <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // outputs
    // all straight from flip-flops, no logic after the registers
    assign O_PREADY = s_q.ready;
    assign O_PSLVERR = s_q.slverr;
    assign O_PRDATA = s_q.rdata;
    assign O_QUESTIONABLE_SUMMARY_BIT = s_q.summary;
    assign O_IRQ = s_q.irq;
endmodule // questionable_status_group

// ===== test/questionable_summary_bit_props.sv
// port checker for the questionable status group
// assumes one core clock and bind onto the top module
`timescale 1ns/1ps
module questionable_summary_bit_props (
    // clock, reset and bus
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic O_PREADY,
    input wire logic O_PSLVERR,
    input wire logic [31:0] O_PRDATA,
    // watched pins
    input wire logic I_OVER_TEMP_TRIP,
    input wire logic I_VOLTAGE_LIMIT_REACHED
);
    // ==========================================
    // properties
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    sequence rd_cond;
        O_PREADY && !I_PWRITE && !O_PSLVERR && I_PADDR == 12'h000;
    endsequence
    a_ready_access: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
        else $error("no ready after setup");
    a_ready_pulse: assert property (O_PREADY |=> !O_PREADY) else $error("ready too long");
    a_idle_quiet: assert property (!I_PSEL |=> !O_PREADY) else $error("ready while idle");
    a_err_ready: assert property (O_PSLVERR |-> O_PREADY) else $error("error without ready");
    a_upper_zero: assert property (O_PREADY && !I_PWRITE |-> O_PRDATA[31:16] == 16'h0000)
        else $error("upper read bits set");
    a_unused_zero: assert property (rd_cond |-> (O_PRDATA[15:0] & 16'h84EF) == 16'h0000)
        else $error("unassigned condition bit set");
    a_temp_mirror: assert property ($stable(I_OVER_TEMP_TRIP)[*5] ##0 rd_cond |->
        O_PRDATA[4] == I_OVER_TEMP_TRIP) else $error("temperature bit wrong");
    a_volt_mirror: assert property ($stable(I_VOLTAGE_LIMIT_REACHED)[*5] ##0 rd_cond |->
        O_PRDATA[8] == I_VOLTAGE_LIMIT_REACHED) else $error("voltage bit wrong");
    a_unmapped_err: assert property (I_PSEL && !I_PENABLE && I_PADDR > 12'h018 |=> O_PSLVERR)
        else $error("unmapped access accepted");
endmodule // questionable_summary_bit_props
bind questionable_status_group questionable_summary_bit_props i_props (.I_CORE_CLK, .I_RESET_N, .I_PSEL,
    .I_PENABLE, .I_PWRITE, .I_PADDR, .O_PREADY, .O_PSLVERR, .O_PRDATA, .I_OVER_TEMP_TRIP,
    .I_VOLTAGE_LIMIT_REACHED);

// ===== test/tb_top.sv
// self-checking bench for the questionable status group
// assumes design files and checker compiled first
`timescale 1ns/1ps
module tb_top;
    // ==========================================
    // drivers and dut
    logic clk = 0;
    logic rst_n = 0;
    logic psel = 0;
    logic pen = 0;
    logic pw = 0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pd = 32'h0000_0000;
    logic [5:0] pin = 6'h00;
    logic [15:0] chain = 16'h0000;
    logic rdy, err, sum, irq, er_v;
    logic [31:0] prd, rd_v;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    questionable_status_group i_dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel),
        .I_PENABLE(pen), .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pd), .I_PSTRB(4'hF),
        .O_PREADY(rdy), .O_PSLVERR(err), .O_PRDATA(prd), .I_OVER_TEMP_TRIP(pin[0]),
        .I_VOLTAGE_LIMIT_REACHED(pin[1]), .I_CURRENT_LIMIT_REACHED(pin[2]),
        .I_SHUTDOWN_ALARM(pin[3]), .I_POWER_LIMIT_REACHED(pin[4]), .I_SENSE_ALARM(pin[5]),
        .I_CHAINED_UNIT_STATUS(chain), .O_QUESTIONABLE_SUMMARY_BIT(sum), .O_IRQ(irq));
    // ==========================================
    // shared tasks
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // entered just after a rising edge; waits for ready, no fixed latency assumed
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pw <= w;
        pa <= a;
        pd <= {16'h0000, d};
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            miscompares++;
            summarize();
        end
        rd_v = prd;
        er_v = err;
        psel <= 1'b0;
        pen <= 1'b0;
        // one idle edge, so a following call never re-raises psel at once
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [15:0] exp);
        apb(1'b0, a, 16'h0000);
        chk(rd_v, {16'h0000, exp});
    endtask
    task automatic pins(input logic [5:0] v);
        pin <= v;
        repeat (6) @(posedge clk);
    endtask
    // ==========================================
    // scenarios
    task automatic t_cond;
        rd(12'h004, 16'h7B10);
        rd(12'h008, 16'h0000);
        rd(12'h00C, 16'h0000);
        rd(12'h010, 16'h0000);
        rd(12'h018, 16'h0000);
        chain <= 16'h8010;
        pins(6'h3F);
        rd(12'h000, 16'h7B10);
        rd(12'h000, 16'h7B10);
        chain <= 16'h84EF;
        pins(6'h00);
        rd(12'h000, 16'h0000);
        rd(12'h00C, 16'h7B10);
        rd(12'h00C, 16'h0000);
    endtask
    task automatic t_filt;
        apb(1'b1, 12'h004, 16'h0010);
        apb(1'b1, 12'h008, 16'h0100);
        pins(6'h03);
        rd(12'h00C, 16'h0010);
        pins(6'h00);
        rd(12'h00C, 16'h0100);
        apb(1'b1, 12'h004, 16'h0100);
        pins(6'h02);
        rd(12'h00C, 16'h0100);
    endtask
    task automatic t_sum;
        pins(6'h00);
        apb(1'b1, 12'h010, 16'h0100);
        chk(sum, 1'b1);
        chk(irq, 1'b0);
        apb(1'b1, 12'h018, 16'h0003);
        repeat (2) @(posedge clk);
        chk(irq, 1'b1);
        rd(12'h00C, 16'h0100);
        repeat (2) @(posedge clk);
        chk(sum, 1'b0);
        apb(1'b1, 12'h014, 16'h0003);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        apb(1'b0, 12'h020, 16'h0000);
        chk(er_v, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_cond();
        t_filt();
        t_sum();
        summarize();
    end
endmodule // tb_top
